// ==== core/cfg_byte_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_bank (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  wr_addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic [7:0]  rd_addr_i,
   output logic      [7:0]  rd_data_o,
   output logic      [63:0] image_o
);
   import pll_cfg_pkg::*;

   logic [7:0] bytes_q [1:8];

   // -----------------------------------------------------------------
   // storage, one byte per offset
   // -----------------------------------------------------------------
   for (genvar i = 1; i <= 8; i++) begin : g_byte
      // byte loads only on a committed write to its own offset
      always_ff @(posedge ref_clk_i) begin
         if (rst_i) begin
            bytes_q[i] <= RST_IMAGE[i];
         end else if (wr_en_i && (wr_addr_i == 8'(i))) begin
            bytes_q[i] <= wr_data_i;
         end
      end
      assign image_o[8*(i-1) +: 8] = bytes_q[i];
   end

   // registered read port; holes read as zero
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else if (is_mapped(rd_addr_i)) begin
         rd_data_o <= bytes_q[rd_addr_i[3:0]];
      end else begin
         rd_data_o <= 8'h00;
      end
   end

endmodule // cfg_byte_bank
`default_nettype wire

// ==== core/pll_cfg_pkg.sv ====
package pll_cfg_pkg;

   // -----------------------------------------------------------------
   // bus addressing and framing
   // -----------------------------------------------------------------
   localparam logic [6:0] DEVICE_ADDR = 7'h6A;   // plain fixed address, compared directly, no strap logic
   localparam logic [7:0] COUNT_RST   = 8'h08;   // byte count returned before any write
   localparam logic [3:0] BITS_RX     = 4'h8;
   localparam logic [3:0] BITS_TX_END = 4'h7;

   typedef enum logic [1:0] {
      PH_ADDR  = 2'h0,
      PH_OFFS  = 2'h1,
      PH_COUNT = 2'h3,
      PH_DATA  = 2'h2
   } phase_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_RX     = 3'h1,
      ST_RX_ACK = 3'h3,
      ST_TX     = 3'h2,
      ST_TX_ACK = 3'h6
   } bus_state_t;

   // -----------------------------------------------------------------
   // register offsets and reset values
   // -----------------------------------------------------------------
   localparam int unsigned OFF_VARIANT  = 1;
   localparam int unsigned OFF_TRIM     = 2;
   localparam int unsigned OFF_PLL3_REF = 3;
   localparam int unsigned OFF_PLL3_FBL = 4;
   localparam int unsigned OFF_PLL3_FLT = 5;
   localparam int unsigned OFF_PLL3_CP  = 6;
   localparam int unsigned OFF_PLL1_CTL = 7;
   localparam int unsigned OFF_PLL1_REF = 8;
   localparam int unsigned OFF_FIRST    = OFF_VARIANT;
   localparam int unsigned OFF_LAST     = OFF_PLL1_REF;

   localparam logic [7:0] RST_VARIANT  = 8'h00;
   localparam logic [7:0] RST_TRIM     = 8'h11;
   localparam logic [7:0] RST_PLL3_REF = 8'h1A;
   localparam logic [7:0] RST_PLL3_FBL = 8'hE0;
   localparam logic [7:0] RST_PLL3_FLT = 8'h11;
   localparam logic [7:0] RST_PLL3_CP  = 8'h6C;
   localparam logic [7:0] RST_PLL1_CTL = 8'h23;
   localparam logic [7:0] RST_PLL1_REF = 8'h1A;
   localparam logic [8:1][7:0] RST_IMAGE = {RST_PLL1_REF, RST_PLL1_CTL, RST_PLL3_CP,
      RST_PLL3_FLT, RST_PLL3_FBL, RST_PLL3_REF, RST_TRIM, RST_VARIANT};

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int unsigned POS_BYP1     = 7;   // offsets 0x03 and 0x08
   localparam int unsigned POS_BYP2     = 6;
   localparam int unsigned POS_FILT_LSB = 3;   // offset 0x05, bits 7..3
   localparam int unsigned POS_CP_SRC   = 7;   // offset 0x06
   localparam int unsigned POS_CP_W_LSB = 3;   // weights x8..x1 in bits 6..3
   localparam int unsigned POS_CP_D24   = 2;
   localparam int unsigned POS_CP_D3    = 1;
   localparam int unsigned POS_CP_BIAS  = 0;
   localparam int unsigned POS_DOUBLER  = 7;   // offset 0x07
   localparam int unsigned POS_P1_BIAS  = 6;
   localparam int unsigned POS_CH2_EN   = 5;
   localparam int unsigned POS_POLE3    = 4;
   localparam logic [5:0]  DIV_BYP1     = 6'h01;
   localparam logic [5:0]  DIV_BYP2     = 6'h02;
   localparam logic [4:0]  CP_DEN_24    = 5'h18;
   localparam logic [4:0]  CP_DEN_3     = 5'h03;

   // offset lies inside the implemented bank
   function automatic logic is_mapped(input logic [7:0] off);
      return (off >= 8'(OFF_FIRST)) && (off <= 8'(OFF_LAST));
   endfunction

endpackage

// ==== core/pll_divider_config_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config_regs (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic      [7:0]  variant_id_o,
   output logic      [7:0]  crystal_trim_o,
   output logic             pll3_ref_bypass_div1_o,
   output logic             pll3_ref_bypass_div2_o,
   output logic      [5:0]  pll3_ref_divider_o,
   output logic      [5:0]  pll3_ref_effective_o,
   output logic      [10:0] pll3_feedback_divider_o,
   output logic      [4:0]  pll3_filter_res_o,
   output logic      [3:0]  pll3_pump_weight_o,
   output logic             pll3_pump_divide_24_o,
   output logic             pll3_pump_divide_3_o,
   output logic             pll3_bias_select_o,
   output logic      [4:0]  pll3_pump_numerator_o,
   output logic      [4:0]  pll3_pump_denominator_o,
   output logic             divider3_source_select_o,
   output logic             pll1_ref_doubler_o,
   output logic             pll1_bias_select_o,
   output logic             pll1_second_channel_enable_o,
   output logic             pll1_third_pole_enable_o,
   output logic      [3:0]  output_divider_five_o,
   output logic      [5:0]  output_divider_five_ratio_o,
   output logic             pll1_ref_bypass_div1_o,
   output logic             pll1_ref_bypass_div2_o,
   output logic      [5:0]  pll1_ref_divider_o,
   output logic      [5:0]  pll1_ref_effective_o
);
   import pll_cfg_pkg::*;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic        scl_q;
   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   bus_state_t  state_q;
   phase_t      phase_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic [7:0]  ptr_q;
   logic [7:0]  count_q;
   logic [7:0]  left_q;
   logic        ack_seen_q;
   logic        wr_en_q;
   logic [7:0]  wr_addr_q;
   logic [7:0]  wr_data_q;
   logic [7:0]  rd_data;
   logic [63:0] image;
   logic [8:1][7:0] src;
   logic        addr_hit;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // fixed bypass wins over the programmable divider, divide-by-1 first
   function automatic logic [5:0] ref_eff(input logic [7:0] b);
      if (b[POS_BYP1]) begin
         return DIV_BYP1;
      end else if (b[POS_BYP2]) begin
         return DIV_BYP2;
      end
      return b[5:0];
   endfunction

   // divider 5 ratio: high pair times low pair
   function automatic logic [5:0] div5_ratio(input logic [3:0] f);
      logic [5:0] hi;
      logic [5:0] lo;
      hi = 6'h01;
      lo = 6'h01;
      case (f[3:2])
         2'h0:    hi = 6'h01;
         2'h1:    hi = 6'h02;
         2'h2:    hi = 6'h04;
         default: hi = 6'h05;
      endcase
      case (f[1:0])
         2'h0:    lo = 6'h01;
         2'h1:    lo = 6'h03;
         2'h2:    lo = 6'h05;
         default: lo = 6'h0A;
      endcase
      return 6'(hi * lo);
   endfunction

   // -----------------------------------------------------------------
   // bus line history and edge detection
   // -----------------------------------------------------------------
   // previous samples, idle high
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign scl_rise  = scl_i & ~scl_q;
   assign scl_fall  = ~scl_i & scl_q;
   assign start_det = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
   assign addr_hit  = (shift_q[7:1] == DEVICE_ADDR);

   // open-drain data line only ever pulls low
   always_ff @(posedge ref_clk_i) begin
      sda_o <= 1'b0;
   end

   // -----------------------------------------------------------------
   // serial protocol engine
   // -----------------------------------------------------------------
   // byte framing, acknowledge, pointer and write commit
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q    <= ST_IDLE;
         phase_q    <= PH_ADDR;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         tx_q       <= 8'h00;
         ptr_q      <= 8'h00;
         count_q    <= COUNT_RST;
         left_q     <= 8'h00;
         ack_seen_q <= 1'b0;
         sda_oe_o   <= 1'b0;
         wr_en_q    <= 1'b0;
         wr_addr_q  <= 8'h00;
         wr_data_q  <= 8'h00;
      end else begin
         wr_en_q <= 1'b0;
         if (stop_det) begin
            state_q  <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (start_det) begin
            state_q   <= ST_RX;
            phase_q   <= PH_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_o  <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shift_q   <= {shift_q[6:0], sda_i};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && (bit_cnt_q == BITS_RX)) begin
                     if ((phase_q == PH_ADDR) && !addr_hit) begin
                        state_q <= ST_IDLE;                      // foreign address, no ack
                     end else begin
                        state_q  <= ST_RX_ACK;
                        sda_oe_o <= 1'b1;
                     end
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall) begin
                     sda_oe_o  <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     state_q   <= ST_RX;
                     case (phase_q)
                        PH_ADDR: begin
                           if (shift_q[0]) begin
                              state_q  <= ST_TX;
                              phase_q  <= PH_COUNT;
                              tx_q     <= count_q;
                              sda_oe_o <= ~count_q[7];
                           end else begin
                              phase_q <= PH_OFFS;
                           end
                        end
                        PH_OFFS: begin
                           ptr_q   <= shift_q;
                           phase_q <= PH_COUNT;
                        end
                        PH_COUNT: begin
                           count_q <= shift_q;
                           left_q  <= shift_q;
                           phase_q <= PH_DATA;
                        end
                        default: begin
                           if (left_q != 8'h00) begin
                              wr_en_q   <= is_mapped(ptr_q);
                              wr_addr_q <= ptr_q;
                              wr_data_q <= shift_q;
                              ptr_q     <= ptr_q + 8'h01;
                              left_q    <= left_q - 8'h01;
                           end
                        end
                     endcase
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == BITS_TX_END) begin
                        state_q  <= ST_TX_ACK;
                        sda_oe_o <= 1'b0;
                     end else begin
                        tx_q      <= {tx_q[6:0], 1'b0};
                        sda_oe_o  <= ~tx_q[6];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) begin
                     ack_seen_q <= ~sda_i;
                  end else if (scl_fall) begin
                     if (ack_seen_q) begin
                        state_q   <= ST_TX;
                        phase_q   <= PH_DATA;
                        tx_q      <= rd_data;
                        sda_oe_o  <= ~rd_data[7];
                        bit_cnt_q <= 4'h0;
                        ptr_q     <= ptr_q + 8'h01;
                     end else begin
                        state_q <= ST_IDLE;                      // host nack ends the read
                     end
                  end
               end
               default: begin
                  state_q  <= ST_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // register storage
   // -----------------------------------------------------------------
   cfg_byte_bank u_bank (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (wr_en_q),
      .wr_addr_i (wr_addr_q),
      .wr_data_i (wr_data_q),
      .rd_addr_i (ptr_q),
      .rd_data_o (rd_data),
      .image_o   (image)
   );

   // reset presents the documented image directly
   assign src = rst_i ? RST_IMAGE : image;

   // -----------------------------------------------------------------
   // field outputs
   // -----------------------------------------------------------------
   // identifier and trim bytes
   always_ff @(posedge ref_clk_i) begin
      variant_id_o   <= src[OFF_VARIANT];
      crystal_trim_o <= src[OFF_TRIM];
   end

   // pll3 reference and feedback dividers
   always_ff @(posedge ref_clk_i) begin
      pll3_ref_bypass_div1_o  <= src[OFF_PLL3_REF][POS_BYP1];
      pll3_ref_bypass_div2_o  <= src[OFF_PLL3_REF][POS_BYP2];
      pll3_ref_divider_o      <= src[OFF_PLL3_REF][5:0];
      pll3_ref_effective_o    <= ref_eff(src[OFF_PLL3_REF]);
      pll3_feedback_divider_o <= {src[OFF_PLL3_FLT][2:0],
                                  src[OFF_PLL3_FBL]};
      pll3_filter_res_o       <= src[OFF_PLL3_FLT][7:POS_FILT_LSB];
   end

   // pll3 charge pump and divider 3 source
   always_ff @(posedge ref_clk_i) begin
      pll3_pump_weight_o       <= src[OFF_PLL3_CP][6:POS_CP_W_LSB];
      pll3_pump_divide_24_o    <= src[OFF_PLL3_CP][POS_CP_D24];
      pll3_pump_divide_3_o     <= src[OFF_PLL3_CP][POS_CP_D3];
      pll3_bias_select_o       <= src[OFF_PLL3_CP][POS_CP_BIAS];
      divider3_source_select_o <= src[OFF_PLL3_CP][POS_CP_SRC];
      pll3_pump_numerator_o    <= 5'({1'b0, src[OFF_PLL3_CP][6:POS_CP_W_LSB]}
                                  << src[OFF_PLL3_CP][POS_CP_BIAS]);
      pll3_pump_denominator_o  <= (src[OFF_PLL3_CP][POS_CP_D24] ? CP_DEN_24 : 5'h00)
                                + (src[OFF_PLL3_CP][POS_CP_D3] ? CP_DEN_3 : 5'h00);
   end

   // pll1 controls and divider 5
   always_ff @(posedge ref_clk_i) begin
      pll1_ref_doubler_o           <= src[OFF_PLL1_CTL][POS_DOUBLER];
      pll1_bias_select_o           <= src[OFF_PLL1_CTL][POS_P1_BIAS];
      pll1_second_channel_enable_o <= src[OFF_PLL1_CTL][POS_CH2_EN];
      pll1_third_pole_enable_o     <= src[OFF_PLL1_CTL][POS_POLE3];
      output_divider_five_o        <= src[OFF_PLL1_CTL][3:0];
      output_divider_five_ratio_o  <= div5_ratio(src[OFF_PLL1_CTL][3:0]);
   end

   // pll1 reference divider
   always_ff @(posedge ref_clk_i) begin
      pll1_ref_bypass_div1_o <= src[OFF_PLL1_REF][POS_BYP1];
      pll1_ref_bypass_div2_o <= src[OFF_PLL1_REF][POS_BYP2];
      pll1_ref_divider_o     <= src[OFF_PLL1_REF][5:0];
      pll1_ref_effective_o   <= ref_eff(src[OFF_PLL1_REF]);
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   addr_ack_drive_a: assert property (
      (state_q == ST_RX) && !start_det && !stop_det && scl_fall && (bit_cnt_q == BITS_RX)
      && (phase_q == PH_ADDR) && addr_hit |=> (state_q == ST_RX_ACK) && sda_oe_o)
      else $error("own address not acknowledged");

   foreign_nack_a: assert property (
      (state_q == ST_RX) && !start_det && !stop_det && scl_fall && (bit_cnt_q == BITS_RX)
      && (phase_q == PH_ADDR) && !addr_hit |=> !sda_oe_o && (state_q == ST_IDLE))
      else $error("foreign address acknowledged");

   commit_after_ack_a: assert property (
      wr_en_q |-> $past(state_q) == ST_RX_ACK && $past(scl_fall) && $past(sda_oe_o))
      else $error("write committed outside acknowledge end");
   commit_mapped_a: assert property (
      wr_en_q |-> is_mapped(wr_addr_q))
      else $error("write committed to unmapped offset");
   fb_low_follow_a: assert property (
      wr_en_q && (wr_addr_q == 8'(OFF_PLL3_FBL)) && !rst_i
      |-> ##2 pll3_feedback_divider_o[7:0] == $past(wr_data_q, 2))
      else $error("feedback divider low byte not applied");

   ref3_bypass_a: assert property (
      pll3_ref_bypass_div1_o |-> pll3_ref_effective_o == DIV_BYP1)
      else $error("pll3 divide-by-1 bypass ignored");
   ref1_bypass_a: assert property (
      !pll1_ref_bypass_div1_o && pll1_ref_bypass_div2_o |-> pll1_ref_effective_o == DIV_BYP2)
      else $error("pll1 divide-by-2 bypass ignored");
   read_count_first_a: assert property (
      (state_q == ST_RX_ACK) && !start_det && !stop_det && scl_fall && (phase_q == PH_ADDR)
      && shift_q[0] |=> (state_q == ST_TX) && (tx_q == $past(count_q)))
      else $error("read does not begin with byte count");

   tx_release_a: assert property (
      (state_q == ST_TX) && !start_det && !stop_det && scl_fall && (bit_cnt_q == BITS_TX_END)
      |=> !sda_oe_o [*1] ##1 (state_q == ST_TX_ACK || state_q == ST_IDLE || state_q == ST_RX))
      else $error("data line held during host acknowledge");

   reset_defaults_a: assert property (
      $past(rst_i) |-> (pll3_feedback_divider_o == 11'd480) && (pll1_ref_divider_o == 6'd26)
      && pll1_second_channel_enable_o && (output_divider_five_ratio_o == 6'd10))
      else $error("defaults wrong after reset");

   write_commit_c: cover property (wr_en_q && (wr_addr_q == 8'(OFF_PLL1_CTL)));
   read_data_c:    cover property ((state_q == ST_TX_ACK) && scl_fall && ack_seen_q);
   foreign_c:      cover property ((state_q == ST_RX) && scl_fall && (bit_cnt_q == BITS_RX)
                                   && (phase_q == PH_ADDR) && !addr_hit);
   stop_c:         cover property (stop_det && (state_q != ST_IDLE));

endmodule // pll_divider_config_regs
`default_nettype wire

// ==== tb/pll_divider_config_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config_regs_test;
   import pll_cfg_pkg::*;
   logic        ref_clk_i, rst_i, scl_i, sda_low, sda_i, sda_o, sda_oe_o;
   logic [7:0]  variant_id_o, crystal_trim_o, cnt, img [8], rd [8];
   logic [10:0] pll3_feedback_divider_o;
   logic [5:0]  pll3_ref_divider_o, pll3_ref_effective_o, pll1_ref_divider_o,
                pll1_ref_effective_o, output_divider_five_ratio_o;
   logic [4:0]  pll3_filter_res_o, pll3_pump_numerator_o, pll3_pump_denominator_o;
   logic [3:0]  pll3_pump_weight_o, output_divider_five_o;
   logic        pll3_ref_bypass_div1_o, pll3_ref_bypass_div2_o, pll3_pump_divide_24_o,
                pll3_pump_divide_3_o, pll3_bias_select_o, divider3_source_select_o,
                pll1_ref_doubler_o, pll1_bias_select_o, pll1_second_channel_enable_o,
                pll1_third_pole_enable_o, pll1_ref_bypass_div1_o, pll1_ref_bypass_div2_o;
   int          errors, compares, acks;
   logic [5:0]  hi [4] = '{6'h01, 6'h02, 6'h04, 6'h05};
   logic [5:0]  lo [4] = '{6'h01, 6'h03, 6'h05, 6'h0A};
   assign sda_i = ~(sda_low | sda_oe_o); // open drain, pull-up
   pll_divider_config_regs pll_divider_config_regs_i (.*);
   smbus_host_model smbus_host_model_i (.ref_clk_i, .sda_i, .scl_o(scl_i), .sda_low_o(sda_low));
   function automatic logic [5:0] eff(input logic [7:0] b);
      return b[7] ? 6'h01 : (b[6] ? 6'h02 : b[5:0]);
   endfunction
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   // field outputs against the expected image
   task automatic fields();
      logic [7:0] c;
      c = img[5];
      chk("id", variant_id_o, img[0]);
      chk("trim", crystal_trim_o, img[1]);
      chk("r3", {pll3_ref_bypass_div1_o, pll3_ref_bypass_div2_o, pll3_ref_divider_o}, img[2]);
      chk("e3", pll3_ref_effective_o, eff(img[2]));
      chk("fb", pll3_feedback_divider_o, {img[4][2:0], img[3]});
      chk("flt", pll3_filter_res_o, img[4][7:3]);
      chk("cp", {divider3_source_select_o, pll3_pump_weight_o, pll3_pump_divide_24_o,
                 pll3_pump_divide_3_o, pll3_bias_select_o}, c);
      chk("sdo", sda_o, 16'h0000);
      chk("num", {pll3_pump_numerator_o, pll3_pump_denominator_o}, {5'(c[6:3] * (c[0] ? 2 : 1)),
          (c[2] ? 5'h18 : 5'h00) + (c[1] ? 5'h03 : 5'h00)});
      chk("c7", {pll1_ref_doubler_o, pll1_bias_select_o, pll1_second_channel_enable_o,
                 pll1_third_pole_enable_o, output_divider_five_o}, img[6]);
      chk("d5", output_divider_five_ratio_o, hi[img[6][3:2]] * lo[img[6][1:0]]);
      chk("r8", {pll1_ref_bypass_div1_o, pll1_ref_bypass_div2_o, pll1_ref_divider_o}, img[7]);
      chk("e8", pll1_ref_effective_o, eff(img[7]));
   endtask
   task automatic close_out();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // reset image, corner and random writes, read-back, foreign address
   initial begin
      errors = 0;
      compares = 0;
      rst_i = 1'b1;
      void'($urandom(32'hBAF4AF0A));
      img = '{8'h00, 8'h11, 8'h1A, 8'hE0, 8'h11, 8'h6C, 8'h23, 8'h1A};
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      @(negedge ref_clk_i);
      fields();
      for (int j = 0; j < 5; j++) begin
         if (j > 0) begin
            for (int i = 0; i < 8; i++) img[i] = (j == 1) ? 8'hFF : (j == 2) ? 8'h40 : 8'($urandom);
            smbus_host_model_i.wr(DEVICE_ADDR, img, acks);
            chk("acks", 16'(acks), 16'h000B);
            repeat (4) @(negedge ref_clk_i);
            fields();
         end
         smbus_host_model_i.rd(DEVICE_ADDR, cnt, rd);
         chk("cnt", cnt, 8'h08);
         for (int i = 0; i < 8; i++) chk("rd", rd[i], img[i]);
      end
      smbus_host_model_i.wr(DEVICE_ADDR ^ 7'h01, rd, acks);
      chk("nack", 16'(acks), 16'h0000);
      fields();
      close_out();
   end
endmodule // pll_divider_config_regs_test
`default_nettype wire

// ==== tb/smbus_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// bus host: block writes and reads, bits changed after falling clock edges
module smbus_host_model (
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic t3();
      repeat (3) @(negedge ref_clk_i);
   endtask
   // one bit, data moved only while clock low
   task automatic bit_io(input logic b, output logic r);
      @(negedge ref_clk_i);
      sda_low_o = ~b;
      t3();
      scl_o = 1'b1;
      t3();
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic start();
      sda_low_o = 1'b0;
      t3();
      scl_o = 1'b1;
      t3();
      sda_low_o = 1'b1;
      t3();
      scl_o = 1'b0;
   endtask
   task automatic put(input logic [7:0] d, inout int acks);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      acks += int'(!r);
   endtask
   // host acks each byte, releases on the last
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
   // address, offset, count, data, stop
   task automatic wr(input logic [6:0] a, input logic [7:0] d [8], output int acks);
      acks = 0;
      start();
      put({a, 1'b0}, acks);
      put(8'h01, acks);
      put(8'h08, acks);
      for (int i = 0; i < 8; i++) put(d[i], acks);
      sda_low_o = 1'b1;
      t3();
      scl_o = 1'b1;
      t3();
      sda_low_o = 1'b0;
      t3();
   endtask
   // offset, repeated start, count then data
   task automatic rd(input logic [6:0] a, output logic [7:0] c, output logic [7:0] d [8]);
      int k;
      start();
      put({a, 1'b0}, k);
      put(8'h01, k);
      start();
      put({a, 1'b1}, k);
      get(1'b0, c);
      for (int i = 0; i < 8; i++) get(i == 7, d[i]);
      sda_low_o = 1'b1;
      t3();
      scl_o = 1'b1;
      t3();
      sda_low_o = 1'b0;
      t3();
   endtask
endmodule // smbus_host_model
`default_nettype wire
